// ===== design/tecc_pkg.sv
// Purpose: Constants for the timer engine configuration and control block
// Assumes: 32-bit APB, 50 MHz system clock
// Notes:   Bit positions use little-endian numbering (bit 31 is MSB)
package tecc_pkg;
   // ***********************************************
   // Register byte offsets
   // ***********************************************
   localparam logic [7:0] OFF_OFFRANGE = 8'h00;
   localparam logic [7:0] OFF_ENGCFG   = 8'h04;
   localparam logic [7:0] OFF_TBCFG    = 8'h08;
   localparam logic [7:0] OFF_TB2VIS   = 8'h0C;
   localparam logic [7:0] OFF_CHANCFG  = 8'h10;
   // ***********************************************
   // Engine configuration fields
   // ***********************************************
   localparam int ECR_FORCE_THREAD_END    = 31;
   localparam int ECR_STOPREQ = 30;
   localparam int ECR_STF     = 28;
   localparam int ECR_ENGINE_HALTED_FLAG    = 23;
   localparam int ECR_FPS_LO  = 16;
   localparam int ECR_CHANNEL_FILTER_MODE_LO = 14;
   localparam int ECR_ETB_LO  = 0;
   // ***********************************************
   // Time base configuration fields
   // ***********************************************
   localparam int TBCR_T2CS_LO = 29;
   localparam logic [2:0] T2CS_RESET = 3'h1;
   // ***********************************************
   // Reset values and scaling
   // ***********************************************
   localparam logic [31:0] OFFRANGE_RESET = 32'h0000_0000;
   localparam logic [2:0]  FPS_RESET      = 3'h0;
   localparam logic [4:0]  ETB_RESET      = 5'h00;
   localparam logic [31:0] CHAN_RESET     = 32'h0000_0000;
   localparam int          ETB_WORD_SHIFT = 9;
   localparam logic [2:0]  SYSCLK_DIV_EIGHT_LAST      = 3'h7;
   localparam logic [23:0] TB2_ONE        = 24'h00_0001;
   localparam int          CLK_PERIOD_NS  = 20;
   // ***********************************************
   // Modes
   // ***********************************************
   typedef enum logic [1:0] {
      FLT_TWO   = 2'h0,
      FLT_RSVD  = 2'h1,
      FLT_THREE = 2'h2,
      FLT_CONT  = 2'h3
   } tecc_filt_e;
   typedef enum logic [2:0] {
      T2_GATED = 3'h0,
      T2_RISE  = 3'h1,
      T2_FALL  = 3'h2,
      T2_BOTH  = 3'h3,
      T2_SYSCLK_DIV_EIGHT  = 3'h4,
      T2_PTB   = 3'h5
   } tecc_t2cs_e;
endpackage

// ===== design/tecc_engine_config.sv
// Functional notes
// - Off-range code memory reads return the 32-bit off-range data register.
// - Host may write an instruction there; engine executes it on runaway fetch.
// - One off-range data register serves both engines; here each instance holds its own.
// - Writing one to force thread end ends the thread; bit self-clears.
// - Stop request gates engine clocks, time bases and sampling; bus runs.
// - After stop request, channel reads give bus error; writes unpredictable.
// - Stop waits for running thread, completes next clock after valid.
// - Stop request ignores host writes while code memory visible is one.
// - Stopped flag set only after stop, local or shared bus stop line.
// - Halted flag set while in halt, including single-step execution.
// - Filter prescaler divides system clock by two to power code plus one.
// - Mode 10 three agreeing samples; mode 11 all half-rate samples agree.
// - Entry table base times 0x200 gives microcode word address.
// - While stopped, time base reads succeed, writes error without effect.
// - Each engine has its own time base configuration registers.
// - Select 000 gates divide-by-eight clock with external time base pin.
// - Selects 001/010/011 count rising, falling or either pin edge.
// - Select 100 ungated divide-by-eight; 101 peripheral timebase input.
// - Time base two select resets to rising external clock edges.
//
// Purpose: Configuration and control registers of one timer engine
// Assumes: One APB slave, one wait state on every access
// Notes:   Instantiate once per engine; every instance holds its own off-range data register
`timescale 1ns/1ps
module tecc_engine_config (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Microengine status
   input  wire logic        threadActive,
   input  wire logic        haltState,
   input  wire logic        codeMemoryVisible,
   input  wire logic        sharedBusStop,
   // Pins and internal time base
   input  wire logic        extTimebaseClk,
   input  wire logic        channelIn,
   input  wire logic        periphTimebase,
   // Engine controls
   output logic [31:0]      offRangeData,
   output logic             forceThreadEnd,
   output logic             engineClockOn,
   output logic [13:0]      entryTableAddr,
   output logic             channelState,
   output logic [23:0]      timeBaseTwo
);
   // ***********************************************
   // Registers
   // ***********************************************
   logic [31:0] offData_q, chanCfg_q, prdata_q;
   logic        pready_q, pslverr_q, force_thread_end_q;
   logic        stopReq_q, stopped_q, halted_q, clkOn_q;
   logic [2:0]  fps_q, t2cs_q, sysclk_div_eight_q;
   logic [1:0]  channel_filter_mode_q;
   logic [4:0]  etb_q;
   logic [13:0] etbAddr_q;
   logic [23:0] tb2_q;
   logic [2:0]  extSync_q, chSync_q;
   logic        extLvl_q, extPrev_q, chLvl_q;
   logic [7:0]  fCnt_q;
   logic        fTick, half_q, ref_q, miss_q, state_q;
   logic [2:0]  smp_q;
   logic        tb2Tick;
   logic        access, wrCommit, hit;
   logic [31:0] rdVal, engCfgRd;
   logic        errVal;

   assign access   = psel && penable && !pready_q;
   assign wrCommit = psel && penable && pready_q && pwrite && !pslverr_q;

   // ***********************************************
   // APB decode
   // ***********************************************
   always_comb begin
      engCfgRd = 32'h0000_0000;
      engCfgRd[tecc_pkg::ECR_STOPREQ] = stopReq_q;
      engCfgRd[tecc_pkg::ECR_STF] = stopped_q;
      engCfgRd[tecc_pkg::ECR_ENGINE_HALTED_FLAG] = halted_q;
      engCfgRd[tecc_pkg::ECR_FPS_LO +: 3] = fps_q;
      engCfgRd[tecc_pkg::ECR_CHANNEL_FILTER_MODE_LO +: 2] = channel_filter_mode_q;
      engCfgRd[tecc_pkg::ECR_ETB_LO +: 5] = etb_q;
      rdVal  = 32'h0000_0000;
      errVal = 1'b0;
      hit    = 1'b1;
      case (paddr)
         tecc_pkg::OFF_OFFRANGE: rdVal = offData_q;
         tecc_pkg::OFF_ENGCFG:   rdVal = engCfgRd;
         tecc_pkg::OFF_TBCFG: begin
            rdVal[tecc_pkg::TBCR_T2CS_LO +: 3] = t2cs_q;
            errVal = pwrite && stopped_q;
         end
         tecc_pkg::OFF_TB2VIS: begin
            rdVal[23:0] = tb2_q;
            errVal = pwrite;
         end
         tecc_pkg::OFF_CHANCFG: begin
            rdVal  = stopReq_q ? 32'h0000_0000 : chanCfg_q;
            errVal = stopReq_q;
         end
         default: hit = 1'b0;
      endcase
      if (!hit) begin
         errVal = 1'b1;
      end
   end

   // One wait state: answer is registered in the access phase
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (access) begin
         pready_q  <= 1'b1;
         pslverr_q <= errVal;
         prdata_q  <= pwrite ? 32'h0000_0000 : rdVal;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // ***********************************************
   // Off-range data, held per engine instance
   // ***********************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         offData_q <= tecc_pkg::OFFRANGE_RESET;
      end else if (wrCommit && paddr == tecc_pkg::OFF_OFFRANGE) begin
         offData_q <= pwdata;
      end
   end

   // ***********************************************
   // Engine configuration
   // ***********************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         fps_q  <= tecc_pkg::FPS_RESET;
         channel_filter_mode_q <= tecc_pkg::FLT_TWO;
         etb_q  <= tecc_pkg::ETB_RESET;
      end else if (wrCommit && paddr == tecc_pkg::OFF_ENGCFG) begin
         fps_q  <= pwdata[tecc_pkg::ECR_FPS_LO +: 3];
         channel_filter_mode_q <= pwdata[tecc_pkg::ECR_CHANNEL_FILTER_MODE_LO +: 2];
         etb_q  <= pwdata[tecc_pkg::ECR_ETB_LO +: 5];
      end
   end

   // Pulse only; the bit always reads back zero
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         force_thread_end_q <= 1'b0;
      end else begin
         force_thread_end_q <= wrCommit && paddr == tecc_pkg::OFF_ENGCFG &&
                   pwdata[tecc_pkg::ECR_FORCE_THREAD_END];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         stopReq_q <= 1'b0;
      end else if (wrCommit && paddr == tecc_pkg::OFF_ENGCFG &&
                   !codeMemoryVisible) begin
         stopReq_q <= pwdata[tecc_pkg::ECR_STOPREQ];
      end
   end

   // Stop only between threads, never mid-thread
   // Clock enable kept as its own flop so the output is registered
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         stopped_q <= 1'b0;
         clkOn_q   <= 1'b1;
      end else if (stopReq_q || sharedBusStop) begin
         if (!threadActive) begin
            stopped_q <= 1'b1;
            clkOn_q   <= 1'b0;
         end
      end else begin
         stopped_q <= 1'b0;
         clkOn_q   <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         halted_q <= 1'b0;
      end else begin
         halted_q <= haltState;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         etbAddr_q <= 14'h0000;
      end else begin
         etbAddr_q <= 14'(etb_q) << tecc_pkg::ETB_WORD_SHIFT;
      end
   end

   // ***********************************************
   // Per-engine time base configuration
   // ***********************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         t2cs_q <= tecc_pkg::T2CS_RESET;
      end else if (wrCommit && paddr == tecc_pkg::OFF_TBCFG) begin
         t2cs_q <= pwdata[tecc_pkg::TBCR_T2CS_LO +: 3];
      end
   end

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         extSync_q <= 3'h0;
         chSync_q  <= 3'h0;
      end else begin
         extSync_q <= {extSync_q[1:0], extTimebaseClk};
         chSync_q  <= {chSync_q[1:0], channelIn};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         extLvl_q  <= 1'b0;
         extPrev_q <= 1'b0;
         chLvl_q   <= 1'b0;
      end else begin
         extPrev_q <= extLvl_q;
         if (extSync_q[1] == extSync_q[2]) begin
            extLvl_q <= extSync_q[2];
         end
         if (chSync_q[1] == chSync_q[2]) begin
            chLvl_q <= chSync_q[2];
         end
      end
   end

   // ***********************************************
   // Time base two clocking
   // ***********************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sysclk_div_eight_q <= 3'h0;
      end else if (!stopped_q) begin
         sysclk_div_eight_q <= sysclk_div_eight_q + 3'h1;
      end
   end

   always_comb begin
      case (t2cs_q)
         tecc_pkg::T2_GATED:
            tb2Tick = sysclk_div_eight_q == tecc_pkg::SYSCLK_DIV_EIGHT_LAST && extLvl_q;
         tecc_pkg::T2_RISE: tb2Tick = extLvl_q && !extPrev_q;
         tecc_pkg::T2_FALL: tb2Tick = !extLvl_q && extPrev_q;
         tecc_pkg::T2_BOTH: tb2Tick = extLvl_q != extPrev_q;
         tecc_pkg::T2_SYSCLK_DIV_EIGHT: tb2Tick = sysclk_div_eight_q == tecc_pkg::SYSCLK_DIV_EIGHT_LAST;
         tecc_pkg::T2_PTB:  tb2Tick = periphTimebase;
         default:           tb2Tick = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         tb2_q <= 24'h00_0000;
      end else if (tb2Tick && !stopped_q) begin
         tb2_q <= tb2_q + tecc_pkg::TB2_ONE;
      end
   end

   // ***********************************************
   // Channel input filter
   // ***********************************************
   // Tick every 2^(code+1) cycles
   // At-or-above compare: a smaller code acts at once, no wrap stall
   assign fTick = fCnt_q >= ((8'h02 << fps_q) - 8'h01);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         fCnt_q <= 8'h00;
         half_q <= 1'b0;
      end else if (!stopped_q) begin
         fCnt_q <= fTick ? 8'h00 : fCnt_q + 8'h01;
         half_q <= !half_q;
      end
   end

   // Continuous mode tracks disagreement between ticks
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ref_q  <= 1'b0;
         miss_q <= 1'b0;
      end else if (!stopped_q) begin
         if (fTick) begin
            ref_q  <= chLvl_q;
            miss_q <= 1'b0;
         end else if (half_q && chLvl_q != ref_q) begin
            miss_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         smp_q   <= 3'h0;
         state_q <= 1'b0;
      end else if (fTick && !stopped_q) begin
         smp_q <= {smp_q[1:0], chLvl_q};
         case (channel_filter_mode_q)
            tecc_pkg::FLT_TWO: begin
               if (smp_q[0] == chLvl_q) begin
                  state_q <= chLvl_q;
               end
            end
            tecc_pkg::FLT_THREE: begin
               if (smp_q[0] == chLvl_q && smp_q[1] == chLvl_q) begin
                  state_q <= chLvl_q;
               end
            end
            tecc_pkg::FLT_CONT: begin
               if (!miss_q && ref_q == chLvl_q) begin
                  state_q <= chLvl_q;
               end
            end
            default: state_q <= state_q;
         endcase
      end
   end

   // ***********************************************
   // Channel configuration (stand-in channel register)
   // ***********************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         chanCfg_q <= tecc_pkg::CHAN_RESET;
      end else if (wrCommit && paddr == tecc_pkg::OFF_CHANCFG) begin
         chanCfg_q <= pwdata;
      end
   end

   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign prdata         = prdata_q;
   assign offRangeData   = offData_q;
   assign forceThreadEnd = force_thread_end_q;
   assign engineClockOn  = clkOn_q;
   assign entryTableAddr = etbAddr_q;
   assign channelState   = state_q;
   assign timeBaseTwo    = tb2_q;

   // ***********************************************
   // Assertions
   // ***********************************************
   sequence s_ecrWrite;
      wrCommit && paddr == tecc_pkg::OFF_ENGCFG;
   endsequence

   sequence s_stopValid;
      (stopReq_q || sharedBusStop) && !threadActive;
   endsequence

   a_force_thread_end_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_ecrWrite ##0 pwdata[tecc_pkg::ECR_FORCE_THREAD_END] |=> forceThreadEnd ##1
      !forceThreadEnd || $past(wrCommit))
      else $error("force end not a pulse");

   a_stop_next: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_stopValid |=> stopped_q)
      else $error("stop did not complete next clock");

   a_stop_thread: assert property (@(posedge sys_clk) disable iff (!resetn)
      !stopped_q && threadActive |=> !stopped_q)
      else $error("stopped during thread");

   a_stop_protect: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_ecrWrite ##0 codeMemoryVisible |=> $stable(stopReq_q))
      else $error("stop request written while visible");

   a_tb2_frozen: assert property (@(posedge sys_clk) disable iff (!resetn)
      stopped_q |=> $stable(tb2_q))
      else $error("time base moved while stopped");

   a_chan_error: assert property (@(posedge sys_clk) disable iff (!resetn)
      access && paddr == tecc_pkg::OFF_CHANCFG && stopReq_q
      |=> pready && pslverr)
      else $error("channel access not refused");

   a_tb_wrerr: assert property (@(posedge sys_clk) disable iff (!resetn)
      access && pwrite && paddr == tecc_pkg::OFF_TBCFG && stopped_q
      |=> pslverr ##1 $stable(t2cs_q))
      else $error("time base write not refused");

   a_halt_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
      haltState [*2] |-> halted_q)
      else $error("halt flag not held");

   a_etb_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> entryTableAddr == 14'($past(etb_q)) * 14'h0200)
      else $error("entry table address wrong");

   a_rise_count: assert property (@(posedge sys_clk) disable iff (!resetn)
      t2cs_q == tecc_pkg::T2_RISE && !stopped_q && extLvl_q && !extPrev_q
      |=> tb2_q == $past(tb2_q) + tecc_pkg::TB2_ONE)
      else $error("rising edge not counted");
endmodule // tecc_engine_config

// ===== tb/tecc_engine_model.sv
// Purpose: Microengine stand-in that runs timed threads
// Assumes: Thread start requests are one-cycle pulses
// Notes:   A forced end cuts the thread short on the next edge
`timescale 1ns/1ps
module tecc_engine_model #(
   parameter int THREAD_LEN = 40
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic resetn,
   // Control
   input  wire logic startThread,
   input  wire logic forceThreadEnd,
   input  wire logic engineClockOn,
   // Status
   output logic      threadActive
);
   int unsigned runCnt_q;
   // Thread ends as if its end instruction ran
   always_ff @(posedge sys_clk) begin
      if (!resetn || forceThreadEnd) begin
         runCnt_q <= 0;
      end else if (startThread && engineClockOn) begin
         runCnt_q <= THREAD_LEN;
      end else if (runCnt_q != 0) begin
         runCnt_q <= runCnt_q - 1;
      end
   end
   assign threadActive = (runCnt_q != 0);
endmodule // tecc_engine_model

// ===== tb/timer_engine_config_ctrl_bench.sv
// Purpose: Self-checking bench for the engine configuration block
// Assumes: APB slave answers after a wait state, thread model on far side
// Notes:   Time base windows are 72 cycles, a multiple of eight
`timescale 1ns/1ps
module timer_engine_config_ctrl_bench;
   logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, offRangeData, rdData;
   logic        rdErr, haltState, codeMemoryVisible, sharedBusStop;
   logic        extTimebaseClk, channelIn, periphTimebase, startThread;
   logic        threadActive, forceThreadEnd, engineClockOn, channelState;
   logic [13:0] entryTableAddr;
   logic [23:0] timeBaseTwo, tbSnap;
   int          errors, n_checks, fteCnt;

   tecc_engine_config i_dut (.sys_clk(sys_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .threadActive(threadActive), .haltState(haltState),
      .codeMemoryVisible(codeMemoryVisible), .sharedBusStop(sharedBusStop),
      .extTimebaseClk(extTimebaseClk), .channelIn(channelIn),
      .periphTimebase(periphTimebase), .offRangeData(offRangeData),
      .forceThreadEnd(forceThreadEnd), .engineClockOn(engineClockOn),
      .entryTableAddr(entryTableAddr), .channelState(channelState),
      .timeBaseTwo(timeBaseTwo));

   tecc_engine_model i_eng (.sys_clk(sys_clk), .resetn(resetn),
      .startThread(startThread), .forceThreadEnd(forceThreadEnd),
      .engineClockOn(engineClockOn), .threadActive(threadActive));

   initial begin
      sys_clk = 1'b0;
      forever #(tecc_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (forceThreadEnd === 1'b1) fteCnt++;
   end

   // ***********************************************
   // Tasks
   // ***********************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got,
                  exp);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic lost(input string msg);
      errors++;
      $display("CHECK FAILED t=%0t timeout %s", $time, msg);
      results();
   endtask

   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) lost("apb");
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic tb2(input logic [2:0] code, input int pin, input int exp);
      apb(1'b1, tecc_pkg::OFF_TBCFG, {code, 29'h0});
      @(posedge sys_clk);
      extTimebaseClk <= (pin == 1);
      cyc(8);
      tbSnap = timeBaseTwo;
      for (int i = 0; i < 64; i++) begin
         @(posedge sys_clk);
         if (pin == 2) extTimebaseClk <= i[2];
         periphTimebase <= (pin == 3) && (i % 4 == 0);
      end
      @(posedge sys_clk);
      extTimebaseClk <= (pin == 1);
      cyc(7);
      chk({8'h00, timeBaseTwo - tbSnap}, exp, "tb2 ticks");
   endtask

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      haltState = 1'b0;
      codeMemoryVisible = 1'b0;
      sharedBusStop = 1'b0;
      extTimebaseClk = 1'b0;
      channelIn = 1'b0;
      periphTimebase = 1'b0;
      startThread = 1'b0;
      cyc(16);
      resetn <= 1'b1;
      apb(1'b0, tecc_pkg::OFF_TBCFG, 32'h0);
      chk(rdData, 32'h2000_0000, "tbcr reset");
      apb(1'b0, tecc_pkg::OFF_ENGCFG, 32'h0);
      chk(rdData, 32'h0, "ecr reset");
      chk(engineClockOn, 1'b1, "clock on");
      $display("test reset done");
      apb(1'b1, tecc_pkg::OFF_OFFRANGE, 32'hA5C3_3C5A);
      apb(1'b0, tecc_pkg::OFF_OFFRANGE, 32'h0);
      chk(rdData, 32'hA5C3_3C5A, "offrange read");
      chk(offRangeData, 32'hA5C3_3C5A, "offrange out");
      apb(1'b0, 8'h14, 32'h0);
      chk(rdErr, 1'b1, "unmapped");
      apb(1'b1, tecc_pkg::OFF_TB2VIS, 32'hFFFF_FFFF);
      chk(rdErr, 1'b1, "visibility write");
      $display("test offrange done");
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h2FFF_FFFE);
      apb(1'b0, tecc_pkg::OFF_ENGCFG, 32'h0);
      chk(rdData, 32'h0007_C01E, "ecr fields");
      chk(entryTableAddr, 14'h3C00, "entry table");
      @(posedge sys_clk);
      haltState <= 1'b1;
      apb(1'b0, tecc_pkg::OFF_ENGCFG, 32'h0);
      chk(rdData, 32'h0087_C01E, "halted flag");
      haltState <= 1'b0;
      startThread <= 1'b1;
      @(posedge sys_clk);
      startThread <= 1'b0;
      cyc(2);
      chk(threadActive, 1'b1, "thread run");
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h8007_C01E);
      cyc(3);
      chk(fteCnt, 1, "force end pulse");
      chk(threadActive, 1'b0, "thread ended");
      apb(1'b0, tecc_pkg::OFF_ENGCFG, 32'h0);
      chk(rdData, 32'h0007_C01E, "force end clears");
      $display("test engine config done");
      tb2(3'h0, 1, 9);
      tb2(3'h0, 0, 0);
      tb2(3'h1, 2, 8);
      tb2(3'h2, 2, 8);
      tb2(3'h3, 2, 16);
      tb2(3'h5, 3, 16);
      tb2(3'h6, 2, 0);
      tb2(3'h4, 0, 9);
      $display("test time base done");
      startThread <= 1'b1;
      @(posedge sys_clk);
      startThread <= 1'b0;
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h4007_C01E);
      apb(1'b0, tecc_pkg::OFF_ENGCFG, 32'h0);
      chk(rdData, 32'h4007_C01E, "stop deferred");
      chk(engineClockOn, 1'b1, "clock during thread");
      apb(1'b0, tecc_pkg::OFF_CHANCFG, 32'h0);
      chk(rdErr, 1'b1, "channel read err");
      for (int n = 0; threadActive !== 1'b0; n++) begin
         if (n > 200) lost("thread");
         @(posedge sys_clk);
      end
      cyc(2);
      chk(engineClockOn, 1'b0, "clock gated");
      apb(1'b0, tecc_pkg::OFF_ENGCFG, 32'h0);
      chk(rdData, 32'h5007_C01E, "stopped flag");
      tbSnap = timeBaseTwo;
      cyc(40);
      chk({8'h00, timeBaseTwo - tbSnap}, 32'h0, "tb2 frozen");
      apb(1'b1, tecc_pkg::OFF_TBCFG, 32'h0);
      chk(rdErr, 1'b1, "tbcr write err");
      apb(1'b0, tecc_pkg::OFF_TBCFG, 32'h0);
      chk({rdErr, rdData[31:1]}, 32'h4000_0000, "tbcr kept");
      codeMemoryVisible <= 1'b1;
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h0007_C01E);
      apb(1'b0, tecc_pkg::OFF_ENGCFG, 32'h0);
      chk(rdData, 32'h5007_C01E, "stop protected");
      codeMemoryVisible <= 1'b0;
      // Flag was seen before the request is turned round
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h0007_C01E);
      cyc(2);
      chk(engineClockOn, 1'b1, "clock back");
      sharedBusStop <= 1'b1;
      cyc(3);
      chk(engineClockOn, 1'b0, "bus stop");
      apb(1'b0, tecc_pkg::OFF_ENGCFG, 32'h0);
      chk(rdData, 32'h1007_C01E, "bus stop flag");
      sharedBusStop <= 1'b0;
      cyc(3);
      $display("test stop done");
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h0007_001E);
      channelIn <= 1'b1;
      cyc(100);
      chk(channelState, 1'b0, "slow filter early");
      cyc(600);
      chk(channelState, 1'b1, "two sample");
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h0000_401E);
      channelIn <= 1'b0;
      cyc(40);
      chk(channelState, 1'b1, "reserved holds");
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h0000_801E);
      cyc(40);
      chk(channelState, 1'b0, "three sample");
      apb(1'b1, tecc_pkg::OFF_ENGCFG, 32'h0002_C01E);
      for (int i = 0; i < 96; i++) begin
         @(posedge sys_clk);
         channelIn <= i[1];
      end
      chk(channelState, 1'b0, "continuous rejects");
      channelIn <= 1'b1;
      cyc(60);
      chk(channelState, 1'b1, "continuous accepts");
      $display("test filter done");
      results();
   end
endmodule // timer_engine_config_ctrl_bench
